// file: rtl/timer_consts.svh
// offsets, field positions, reset values and divider counts of the reload/capture timer
// assumes a 32-bit wishbone data path, one register per aligned word
`ifndef TIMER_CONSTS_SVH
`define TIMER_CONSTS_SVH

// register byte offsets
`define TMR_OFS_CTRL 8'h00
`define TMR_OFS_CLKSEL 8'h04
`define TMR_OFS_RELOAD 8'h08
`define TMR_OFS_COUNT 8'h0C
`define TMR_OFS_STATUS 8'h10
`define TMR_OFS_MASK 8'h14

// timer_control_register fields
`define TMR_CTRL_HI_FLAG 7
`define TMR_CTRL_LO_FLAG 6
`define TMR_CTRL_LO_IEN 5
`define TMR_CTRL_CAP_EN 4
`define TMR_CTRL_SPLIT 3
`define TMR_CTRL_RUN 2
`define TMR_CTRL_CAP_SRC 1
`define TMR_CTRL_EXT_CLK 0

// clock_control_register fields
`define TMR_CLK_LO_SEL 0
`define TMR_CLK_HI_SEL 1

// interrupt status and mask fields
`define TMR_IRQ_HI_OVF 0
`define TMR_IRQ_LO_OVF 1
`define TMR_IRQ_CAPTURE 2

// reset values
`define TMR_RST_CTRL 8'h00
`define TMR_RST_CLKSEL 2'h0
`define TMR_RST_BYTE 8'h00
`define TMR_RST_IRQ 3'h0

// prescaler counts
`define TMR_SYS_DIV 4'hC
`define TMR_EXT_DIV 3'h7

`endif

// file: rtl/timer_pkg.sv
// types shared by the reload/capture timer files
// assumes timer_consts.svh for all numeric constants
package timer_pkg;

   typedef enum logic [1:0] {
      MODE_RELOAD16,
      MODE_SPLIT8,
      MODE_CAPTURE16,
      MODE_CAPTURE8
   } timer_mode_e;

endpackage : timer_pkg

// file: rtl/timer_prescaler.sv
// prescaler: system clock divided by 12 and synchronised external clock divided by 8
// assumes ext_clk_i is asynchronous and slower than half the system clock
`timescale 1ns/1ps
`default_nettype none
`include "timer_consts.svh"

module timer_prescaler (
   // system
   input wire logic clk_i,
   input wire logic rst_i,
   // external oscillator
   input wire logic ext_clk_i,
   // ticks, one cycle each
   output logic sys_div_tick_o,
   output logic ext_div_tick_o
);

   logic ext_meta_q, ext_meta_d;
   logic ext_sync_q, ext_sync_d;
   logic ext_prev_q, ext_prev_d;
   logic [3:0] sys_cnt_q, sys_cnt_d;
   logic [2:0] ext_cnt_q, ext_cnt_d;
   logic sys_tick_q, sys_tick_d;
   logic ext_tick_q, ext_tick_d;

   always_comb begin
      ext_meta_d = ext_clk_i;
      ext_sync_d = ext_meta_q;
      ext_prev_d = ext_sync_q;
      sys_cnt_d = sys_cnt_q + 4'h1;
      sys_tick_d = 1'b0;
      if (sys_cnt_q == `TMR_SYS_DIV - 4'h1) begin
         sys_cnt_d = 4'h0;
         sys_tick_d = 1'b1;
      end
      ext_cnt_d = ext_cnt_q;
      ext_tick_d = 1'b0;
      // count rising edges of the synchronised external clock
      if (ext_sync_q && !ext_prev_q) begin
         ext_cnt_d = ext_cnt_q + 3'h1;
         if (ext_cnt_q == `TMR_EXT_DIV) begin
            ext_tick_d = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ext_meta_q <= 1'b0;
         ext_sync_q <= 1'b0;
         ext_prev_q <= 1'b0;
         sys_cnt_q <= 4'h0;
         ext_cnt_q <= 3'h0;
         sys_tick_q <= 1'b0;
         ext_tick_q <= 1'b0;
      end else begin
         ext_meta_q <= ext_meta_d;
         ext_sync_q <= ext_sync_d;
         ext_prev_q <= ext_prev_d;
         sys_cnt_q <= sys_cnt_d;
         ext_cnt_q <= ext_cnt_d;
         sys_tick_q <= sys_tick_d;
         ext_tick_q <= ext_tick_d;
      end
   end

   assign sys_div_tick_o = sys_tick_q;
   assign ext_div_tick_o = ext_tick_q;

endmodule : timer_prescaler

`default_nettype wire

// file: rtl/reload_capture_timer.sv
// sixteen-bit reload/capture timer with a classic wishbone register slave
// assumes sof_i is a one-cycle pulse and lfo_i a level, both synchronous to clk_i
`timescale 1ns/1ps
`default_nettype none
`include "timer_consts.svh"

module reload_capture_timer
   import timer_pkg::*;
(
   // system
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // clock and capture sources
   input wire logic ext_clk_i,
   input wire logic sof_i,
   input wire logic lfo_i,
   // interrupt
   output logic irq_o
);

   logic [7:0] ctrl_q, ctrl_d;
   logic [1:0] clksel_q, clksel_d;
   logic [7:0] reload_lo_q, reload_lo_d;
   logic [7:0] reload_hi_q, reload_hi_d;
   logic [7:0] count_lo_q, count_lo_d;
   logic [7:0] count_hi_q, count_hi_d;
   logic [2:0] status_q, status_d;
   logic [2:0] mask_q, mask_d;
   logic ack_q, ack_d;
   logic [31:0] rdata_q, rdata_d;
   logic lfo_q, lfo_d;

   logic sys_div_tick;
   logic ext_div_tick;
   logic lo_tick;
   logic hi_tick;
   logic lo_ovf;
   logic hi_ovf;
   logic capture;
   logic access;
   logic wr;
   logic rd;
   logic [15:0] count16;
   logic [15:0] count_inc;
   logic [2:0] status_clr;
   logic [2:0] status_evt;
   logic hit_reload;
   logic hit_count;
   logic hit_status;
   timer_mode_e mode;

   timer_prescaler u_prescaler (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ext_clk_i(ext_clk_i),
      .sys_div_tick_o(sys_div_tick),
      .ext_div_tick_o(ext_div_tick)
   );

   // per-half clock source
   function automatic logic half_tick(input logic sel, input logic ext, input logic sdiv, input logic xdiv);
      half_tick = sel ? 1'b1 : (ext ? xdiv : sdiv);
   endfunction : half_tick

   assign lo_tick = half_tick(clksel_q[`TMR_CLK_LO_SEL], ctrl_q[`TMR_CTRL_EXT_CLK],
                              sys_div_tick, ext_div_tick);
   assign hi_tick = half_tick(clksel_q[`TMR_CLK_HI_SEL], ctrl_q[`TMR_CTRL_EXT_CLK],
                              sys_div_tick, ext_div_tick);

   assign access = cyc_i && stb_i && ack_q;
   assign wr = access && we_i;
   assign rd = access && !we_i;
   assign count16 = {count_hi_q, count_lo_q};
   assign count_inc = count16 + 16'h0001;

   // register decode shared by the counter and status logic
   assign hit_reload = (adr_i == `TMR_OFS_RELOAD);
   assign hit_count = (adr_i == `TMR_OFS_COUNT);
   assign hit_status = (adr_i == `TMR_OFS_STATUS);

   always_comb begin
      unique case ({ctrl_q[`TMR_CTRL_CAP_EN], ctrl_q[`TMR_CTRL_SPLIT]})
         2'b00: mode = MODE_RELOAD16;
         2'b01: mode = MODE_SPLIT8;
         2'b10: mode = MODE_CAPTURE16;
         2'b11: mode = MODE_CAPTURE8;
      endcase
   end

   // lfo_q resets low, the idle level of the line, so reset makes no false edge
   always_comb begin
      lfo_d = lfo_i;
      capture = 1'b0;
      if (ctrl_q[`TMR_CTRL_CAP_EN]) begin
         capture = ctrl_q[`TMR_CTRL_CAP_SRC] ? (lfo_i && !lfo_q) : sof_i;
      end
   end

   // counters, reload bytes and flags
   always_comb begin
      count_lo_d = count_lo_q;
      count_hi_d = count_hi_q;
      reload_lo_d = reload_lo_q;
      reload_hi_d = reload_hi_q;
      lo_ovf = 1'b0;
      hi_ovf = 1'b0;
      unique case (mode)
         MODE_RELOAD16, MODE_CAPTURE16: begin
            if (ctrl_q[`TMR_CTRL_RUN] && lo_tick) begin
               count_lo_d = count_inc[7:0];
               count_hi_d = count_inc[15:8];
               lo_ovf = (count_lo_q == 8'hFF);
               hi_ovf = (count16 == 16'hFFFF);
               // capture modes never reload, so the count runs freely through zero
               if (hi_ovf && mode == MODE_RELOAD16) begin
                  count_lo_d = reload_lo_q;
                  count_hi_d = reload_hi_q;
               end
            end
         end
         MODE_SPLIT8, MODE_CAPTURE8: begin
            // the low half ignores the run bit in both split modes
            if (lo_tick) begin
               count_lo_d = count_lo_q + 8'h01;
               lo_ovf = (count_lo_q == 8'hFF);
               if (lo_ovf && mode == MODE_SPLIT8) begin
                  count_lo_d = reload_lo_q;
               end
            end
            if (ctrl_q[`TMR_CTRL_RUN] && hi_tick) begin
               count_hi_d = count_hi_q + 8'h01;
               hi_ovf = (count_hi_q == 8'hFF);
               if (hi_ovf && mode == MODE_SPLIT8) begin
                  count_hi_d = reload_hi_q;
               end
            end
         end
      endcase
      // software writes to the counter win over counting
      if (wr && hit_count) begin
         if (sel_i[0]) begin
            count_lo_d = dat_i[7:0];
         end
         if (sel_i[1]) begin
            count_hi_d = dat_i[15:8];
         end
      end
      // a capture wins over a software write to the reload bytes
      if (capture) begin
         reload_lo_d = count_lo_q;
         reload_hi_d = count_hi_q;
      end else if (wr && hit_reload) begin
         if (sel_i[0]) begin
            reload_lo_d = dat_i[7:0];
         end
         if (sel_i[1]) begin
            reload_hi_d = dat_i[15:8];
         end
      end
   end

   // registers written by software and overflow flags
   always_comb begin
      ctrl_d = ctrl_q;
      clksel_d = clksel_q;
      mask_d = mask_q;
      if (wr && sel_i[0]) begin
         unique case (adr_i)
            `TMR_OFS_CTRL: ctrl_d = dat_i[7:0];
            `TMR_OFS_CLKSEL: clksel_d = dat_i[1:0];
            `TMR_OFS_MASK: mask_d = dat_i[2:0];
            default: ;
         endcase
      end
      // hardware only ever sets the flags; a set wins over a software clear
      if (hi_ovf) begin
         ctrl_d[`TMR_CTRL_HI_FLAG] = 1'b1;
      end
      if (lo_ovf) begin
         ctrl_d[`TMR_CTRL_LO_FLAG] = 1'b1;
      end
   end

   // interrupt status: one sticky bit per source
   assign status_evt[`TMR_IRQ_HI_OVF] = hi_ovf;
   assign status_evt[`TMR_IRQ_LO_OVF] = lo_ovf && ctrl_q[`TMR_CTRL_LO_IEN];
   assign status_evt[`TMR_IRQ_CAPTURE] = capture;
   // a status read clears only the bits it returned, so a later event is not lost
   assign status_clr = (rd && hit_status) ? rdata_q[2:0] : 3'h0;

   // an event in the clearing cycle wins over the clear
   for (genvar i = 0; i < 3; i++) begin : g_status
      assign status_d[i] = (status_q[i] && !status_clr[i]) || status_evt[i];
   end

   // bus answer: ack one cycle after the request, read data ready with it
   always_comb begin
      ack_d = cyc_i && stb_i && !ack_q;
      rdata_d = rdata_q;
      if (ack_d && !we_i) begin
         rdata_d = 32'h0000_0000;
         unique case (adr_i)
            `TMR_OFS_CTRL: rdata_d[7:0] = ctrl_q;
            `TMR_OFS_CLKSEL: rdata_d[1:0] = clksel_q;
            `TMR_OFS_RELOAD: rdata_d[15:0] = {reload_hi_q, reload_lo_q};
            `TMR_OFS_COUNT: rdata_d[15:0] = count16;
            `TMR_OFS_STATUS: rdata_d[2:0] = status_q;
            `TMR_OFS_MASK: rdata_d[2:0] = mask_q;
            default: ;
         endcase
      end
   end

   // counters and reload bytes
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         reload_lo_q <= `TMR_RST_BYTE;
         reload_hi_q <= `TMR_RST_BYTE;
         count_lo_q <= `TMR_RST_BYTE;
         count_hi_q <= `TMR_RST_BYTE;
      end else begin
         reload_lo_q <= reload_lo_d;
         reload_hi_q <= reload_hi_d;
         count_lo_q <= count_lo_d;
         count_hi_q <= count_hi_d;
      end
   end

   // software registers and overflow flags
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_q <= `TMR_RST_CTRL;
         clksel_q <= `TMR_RST_CLKSEL;
         mask_q <= `TMR_RST_IRQ;
      end else begin
         ctrl_q <= ctrl_d;
         clksel_q <= clksel_d;
         mask_q <= mask_d;
      end
   end

   // interrupt status
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         status_q <= `TMR_RST_IRQ;
      end else begin
         status_q <= status_d;
      end
   end

   // bus answer
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
      end else begin
         ack_q <= ack_d;
         rdata_q <= rdata_d;
      end
   end

   // capture edge detector
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lfo_q <= 1'b0;
      end else begin
         lfo_q <= lfo_d;
      end
   end

   assign ack_o = ack_q;
   assign dat_o = rdata_q;
   assign irq_o = |(status_q & mask_q);

endmodule : reload_capture_timer

`default_nettype wire

// file: sim/timer_sva.sv
// port checker for the reload/capture timer
// assumes it is bound onto reload_capture_timer, one clock domain
`timescale 1ns/1ps
`default_nettype none
`include "timer_consts.svh"
module timer_sva (
   // system
   input wire logic clk_i,
   input wire logic rst_i,
   // bus
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   input wire logic [31:0] dat_o,
   input wire logic ack_o,
   // events and interrupt
   input wire logic sof_i,
   input wire logic lfo_i,
   input wire logic irq_o
);
   logic [7:0] ctrl_q, ctrl_d, mask_q, mask_d;
   logic wr;
   assign wr = ack_o && we_i && sel_i[0];
   // shadow of the control and mask bytes, updated at the accepting edge
   always_comb begin
      ctrl_d = ctrl_q;
      mask_d = mask_q;
      if (wr && adr_i == `TMR_OFS_CTRL) ctrl_d = dat_i[7:0];
      if (wr && adr_i == `TMR_OFS_MASK) mask_d = dat_i[7:0];
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_q <= 8'h00;
         mask_q <= 8'h00;
      end else begin
         ctrl_q <= ctrl_d;
         mask_q <= mask_d;
      end
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   AST_ACK_AFTER_REQ: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
      else $error("ack missing after request");
   AST_ACK_ONE_CYCLE: assert property (ack_o |=> !ack_o)
      else $error("ack longer than one cycle");
   AST_ACK_HAS_REQ: assert property (ack_o |-> $past(cyc_i && stb_i))
      else $error("ack without request");
   AST_DAT_HOLDS: assert property (!ack_o |-> $stable(dat_o))
      else $error("read data changed outside ack");
   AST_IRQ_SW_CLEAR: assert property ($fell(irq_o) |-> $past(ack_o))
      else $error("interrupt dropped without software access");
   AST_IRQ_MASKED: assert property (irq_o |-> mask_q[2:0] != 3'h0)
      else $error("interrupt with all sources masked");
   AST_CAP_SOF: assert property (ctrl_q[4] && !ctrl_q[1] && sof_i && mask_q[2] && !ack_o |=> irq_o)
      else $error("frame capture gave no interrupt");
   AST_CAP_LFO: assert property (ctrl_q[4] && ctrl_q[1] && lfo_i && !$past(lfo_i) && mask_q[2] && !ack_o
      |=> irq_o)
      else $error("oscillator capture gave no interrupt");
   AST_WORD_WIDTH: assert property (ack_o && !we_i && (adr_i == `TMR_OFS_RELOAD || adr_i == `TMR_OFS_COUNT)
      |-> dat_o[31:16] == 16'h0000)
      else $error("upper read bits not zero");
   AST_STATUS_WIDTH: assert property (ack_o && !we_i && adr_i == `TMR_OFS_STATUS |-> dat_o[31:3] == 29'h0)
      else $error("status read has stray bits");
endmodule : timer_sva
bind reload_capture_timer timer_sva u_sva (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
   .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .sof_i(sof_i),
   .lfo_i(lfo_i), .irq_o(irq_o));
`default_nettype wire

// file: sim/testbench.sv
// self-checking bench for the reload/capture timer
// assumes the register offsets of timer_consts.svh and a 10 MHz clock
`timescale 1ns/1ps
`default_nettype none
`include "timer_consts.svh"
module testbench;
   logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
   logic ext_clk_i = 0, sof_i = 0, lfo_i = 0, ack_o, irq_o;
   logic [7:0] adr_i = 8'h00;
   logic [3:0] sel_i = 4'h0;
   logic [31:0] dat_i = 32'h0, dat_o, r;
   int bad_count = 0, n_checks = 0;
   always #50 clk_i = ~clk_i;
   always #230 ext_clk_i = ~ext_clk_i;
   reload_capture_timer dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
      .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .ext_clk_i(ext_clk_i),
      .sof_i(sof_i), .lfo_i(lfo_i), .irq_o(irq_o));
   task automatic conclude;
      if (n_checks > 0 && bad_count == 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : conclude
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      n_checks++;
      if (s !== e) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d, input logic [3:0] s);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= d;
      sel_i <= s;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 50);
      r = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      if (n >= 50) bad_count++;
   endtask : wb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      wb(a, 1'b1, d, 4'hF);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
      wb(a, 1'b0, 32'h0, 4'hF);
      chk(nm, r, e);
   endtask : rd
   task automatic ci(input logic e);
      @(negedge clk_i);
      chk("irq", {31'h0, irq_o}, {31'h0, e});
   endtask : ci
   // one-cycle capture trigger: 1 for the oscillator line, 0 for frame start
   task automatic ev(input logic l);
      @(posedge clk_i);
      if (l) lfo_i <= 1'b1;
      else sof_i <= 1'b1;
      @(posedge clk_i);
      lfo_i <= 1'b0;
      sof_i <= 1'b0;
   endtask : ev
   // counts from zero over a fixed span and checks the tick rate
   task automatic span(input logic [1:0] cs, input logic [7:0] ct, input int w, input logic [15:0] lo, hi);
      wr(`TMR_OFS_CTRL, 32'h0);
      wr(`TMR_OFS_CLKSEL, {30'h0, cs});
      wr(`TMR_OFS_COUNT, 32'h0);
      wr(`TMR_OFS_CTRL, {24'h0, ct});
      repeat (w) @(posedge clk_i);
      wr(`TMR_OFS_CTRL, 32'h0);
      wb(`TMR_OFS_COUNT, 1'b0, 32'h0, 4'hF);
      chk("rate", {31'h0, r[15:0] >= lo && r[15:0] <= hi}, 32'h1);
   endtask : span
   initial begin
      #1000000;
      bad_count++;
      conclude();
   end
   initial begin
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(`TMR_OFS_CTRL, 32'h0, "ctrl");
      rd(`TMR_OFS_RELOAD, 32'h0, "reload");
      rd(`TMR_OFS_STATUS, 32'h0, "status");
      wr(8'h18, 32'hFFFFFFFF);
      rd(8'h18, 32'h0, "unmapped");
      wb(`TMR_OFS_CTRL, 1'b1, 32'h04, 4'hE);
      rd(`TMR_OFS_CTRL, 32'h0, "ctrl_lane");
      wr(`TMR_OFS_MASK, 32'h7);
      wr(`TMR_OFS_CLKSEL, 32'h1);
      wr(`TMR_OFS_RELOAD, 32'hFF00);
      wr(`TMR_OFS_COUNT, 32'hFFFA);
      wr(`TMR_OFS_CTRL, 32'h04);
      repeat (10) @(posedge clk_i);
      ci(1'b1);
      rd(`TMR_OFS_CTRL, 32'hC4, "ctrl");
      rd(`TMR_OFS_STATUS, 32'h1, "status");
      ci(1'b0);
      rd(`TMR_OFS_CTRL, 32'hC4, "ctrl");
      wr(`TMR_OFS_CTRL, 32'h0);
      wb(`TMR_OFS_COUNT, 1'b0, 32'h0, 4'hF);
      chk("count_hi", r[15:8], 32'hFF);
      rd(`TMR_OFS_CTRL, 32'h0, "ctrl");
      wr(`TMR_OFS_COUNT, 32'h00FE);
      wr(`TMR_OFS_CTRL, 32'h24);
      repeat (4) @(posedge clk_i);
      rd(`TMR_OFS_STATUS, 32'h2, "status");
      rd(`TMR_OFS_CTRL, 32'h64, "ctrl");
      wr(`TMR_OFS_CTRL, 32'h0);
      wr(`TMR_OFS_CLKSEL, 32'h3);
      wr(`TMR_OFS_RELOAD, 32'h80F0);
      wr(`TMR_OFS_COUNT, 32'hFFFE);
      wr(`TMR_OFS_CTRL, 32'h08);
      repeat (4) @(posedge clk_i);
      rd(`TMR_OFS_CTRL, 32'h48, "ctrl");
      wb(`TMR_OFS_COUNT, 1'b0, 32'h0, 4'hF);
      chk("split_hi", r[15:8], 32'hFF);
      chk("split_lo", r[7:4], 32'hF);
      wr(`TMR_OFS_CTRL, 32'h0C);
      repeat (2) @(posedge clk_i);
      rd(`TMR_OFS_STATUS, 32'h1, "status");
      wr(`TMR_OFS_CTRL, 32'h0);
      wb(`TMR_OFS_COUNT, 1'b0, 32'h0, 4'hF);
      chk("split_hi", r[15:12], 32'h8);
      wr(`TMR_OFS_MASK, 32'h2);
      wr(`TMR_OFS_COUNT, 32'h00FE);
      wr(`TMR_OFS_CTRL, 32'h28);
      repeat (4) @(posedge clk_i);
      ci(1'b1);
      rd(`TMR_OFS_STATUS, 32'h2, "status");
      wr(`TMR_OFS_CTRL, 32'h0);
      wr(`TMR_OFS_MASK, 32'h7);
      span(2'h1, 8'h04, 120, 16'h0078, 16'h007E);
      span(2'h2, 8'h04, 120, 16'h0009, 16'h000B);
      span(2'h2, 8'h05, 368, 16'h0008, 16'h000B);
      wr(`TMR_OFS_CTRL, 32'h10);
      wr(`TMR_OFS_COUNT, 32'h1230);
      ev(1'b0);
      ci(1'b1);
      wb(`TMR_OFS_RELOAD, 1'b0, 32'h0, 4'hF);
      chk("cap_sof", r[15:4], 32'h123);
      rd(`TMR_OFS_STATUS, 32'h4, "status");
      wr(`TMR_OFS_CTRL, 32'h12);
      wr(`TMR_OFS_COUNT, 32'h5670);
      ev(1'b1);
      wb(`TMR_OFS_RELOAD, 1'b0, 32'h0, 4'hF);
      chk("cap_lfo", r[15:4], 32'h567);
      wr(`TMR_OFS_CTRL, 32'h10);
      wr(`TMR_OFS_COUNT, 32'h9AB0);
      ev(1'b1);
      wb(`TMR_OFS_RELOAD, 1'b0, 32'h0, 4'hF);
      chk("cap_src", r[15:4], 32'h567);
      wr(`TMR_OFS_CTRL, 32'h18);
      wr(`TMR_OFS_COUNT, 32'h3300);
      ev(1'b0);
      wb(`TMR_OFS_RELOAD, 1'b0, 32'h0, 4'hF);
      chk("cap_split", r[15:8], 32'h33);
      wr(`TMR_OFS_CLKSEL, 32'h1);
      wr(`TMR_OFS_CTRL, 32'h14);
      wr(`TMR_OFS_COUNT, 32'hFFFE);
      repeat (4) @(posedge clk_i);
      wb(`TMR_OFS_COUNT, 1'b0, 32'h0, 4'hF);
      chk("cap_wrap", r[15:8], 32'h00);
      rd(`TMR_OFS_CTRL, 32'hD4, "ctrl");
      conclude();
   end
endmodule : testbench
`default_nettype wire
